/* File: hw/mmc_pkg.sv */
/*
  Package for the memory map configuration block: register offsets, field
  positions, reset values and the memory region constants.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package mmc_pkg;

  // I/O port offsets of the two encoding registers.
  localparam logic [8:0] MMC_OFS_ENC2   = 9'h0E0;
  localparam logic [8:0] MMC_OFS_ENC1   = 9'h0E1;
  // Extended setup space offsets.
  localparam logic [8:0] MMC_OFS_SIZE   = 9'h181;
  localparam logic [8:0] MMC_OFS_BANKEN = 9'h182;
  localparam logic [8:0] MMC_OFS_SPLHI  = 9'h183;
  localparam logic [8:0] MMC_OFS_WIN0   = 9'h184;

  // Reset values.
  localparam logic [7:0] MMC_RST_ENC1   = 8'hEB;
  localparam logic [7:0] MMC_RST_ENC2   = 8'hE2;
  localparam logic [7:0] MMC_RST_SIZE   = 8'h00;
  localparam logic [3:0] MMC_RST_BANKEN = 4'hF;
  localparam logic [7:0] MMC_RST_SPLHI  = 8'h00;
  localparam logic [5:0] MMC_RST_WIN0   = 6'h00;

  // Field positions in the first encoding register.
  localparam int MMC_B_PARITY_DIS = 0;
  localparam int MMC_B_SHADOW     = 1;
  localparam int MMC_B_SPLIT512   = 2;
  localparam int MMC_B_SPLIT_DIS  = 3;
  localparam int MMC_B_CODE_LO    = 4;
  localparam int MMC_B_CODE_HI    = 5;
  // Reserved bits of the second encoding register read as one.
  localparam logic [1:0] MMC_ENC2_RSVD = 2'h3;

  // Part size codes.
  localparam logic [1:0] MMC_SZ_256K = 2'h0;
  localparam logic [1:0] MMC_SZ_1M   = 2'h2;
  localparam logic [1:0] MMC_SZ_4M   = 2'h3;

  // Region boundaries, in 4 KB pages of the 32-bit address.
  localparam logic [19:0] MMC_PG_640K = 20'h000A0;
  localparam logic [19:0] MMC_PG_512K = 20'h00080;
  localparam logic [19:0] MMC_PG_ROM  = 20'h000E0;
  localparam logic [19:0] MMC_PG_1M   = 20'h00100;
  localparam logic [19:0] MMC_PG_256K = 20'h00040;
  localparam logic [19:0] MMC_PG_384K = 20'h00060;

  // Decode result kinds.
  typedef enum logic [4:0] {
    MMC_T_NONE  = 5'h01,
    MMC_T_RAM   = 5'h02,
    MMC_T_ROM   = 5'h04,
    MMC_T_CHAN  = 5'h08,
    MMC_T_SPLIT = 5'h10
  } mmc_target_t;

endpackage : mmc_pkg

/* File: hw/mmc_cfg_if.sv */
/*
  Interface carrying the decoded configuration from the register bank to
  the address decoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mmc_cfg_if;
  logic       shadow_rom_select;   // Reads of top ROM region go to ROM.
  logic       low_split_point_select; // One ends base RAM at 512K.
  logic       split_map_disable;   // One turns off the split region.
  logic [11:0] split_start;        // Split start address bits 31..20.
  logic [3:0] bank_en;             // Per bank enable.
  logic [7:0] part_size;           // Two bits per bank.
  logic [5:0] win0;                // Bank 0 base bits 25..20.
  logic [3:0] compat_lo;           // Compatibility-mode codes.
  modport bank (output shadow_rom_select, low_split_point_select, split_map_disable,
                output split_start, bank_en, part_size, win0, compat_lo);
  modport dec (input shadow_rom_select, low_split_point_select, split_map_disable,
               input split_start, bank_en, part_size, win0, compat_lo);
endinterface : mmc_cfg_if
`default_nettype wire

/* File: hw/mmc_decode.sv */
/*
  Combinational memory decoder: classifies one address against the current
  configuration and gives the bank hit.
  Assumes the configuration is stable around the sampling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_decode
  import mmc_pkg::*;
(
  mmc_cfg_if.dec          cfg,
  input  wire logic [31:0] addr,
  input  wire logic        wr,
  output mmc_target_t      target,
  output logic [3:0]       bank_hit
);

  // Log2 of bank size in MB for a part code.
  function automatic logic [2:0] mmc_sz_sh(input logic [1:0] c);
    unique case (c)
      MMC_SZ_1M: mmc_sz_sh = 3'h2;
      MMC_SZ_4M: mmc_sz_sh = 3'h4;
      default:   mmc_sz_sh = 3'h0;
    endcase
  endfunction : mmc_sz_sh

  logic [19:0] pg;     // Address in 4 KB pages.
  logic [19:0] sp_pg;  // Split base in pages.
  logic [19:0] sp_len; // Split length in pages.
  logic [5:0]  win_m;  // Window base masked to alignment.
  logic [2:0]  sh0;    // Bank 0 size shift.

  assign pg    = addr[31:12];
  assign sp_pg = {cfg.split_start, 8'h00};
  assign sp_len = cfg.low_split_point_select ? MMC_PG_384K : MMC_PG_256K; // [R7]
  assign sh0   = mmc_sz_sh(cfg.part_size[1:0]);
  assign win_m = cfg.win0 & ~((6'h01 << sh0) - 6'h01); // [R16] [R17]

  // Region classification, re-evaluated on every address.  [R24]
  always_comb begin
    target   = MMC_T_NONE;
    bank_hit = 4'h0;
    if (pg >= MMC_PG_ROM && pg < MMC_PG_1M) begin
      if (cfg.shadow_rom_select)
        target = wr ? MMC_T_RAM : MMC_T_ROM;       // [R1]
      else
        target = wr ? MMC_T_CHAN : MMC_T_RAM;      // [R2]
    end else if (pg < (cfg.low_split_point_select ? MMC_PG_512K : MMC_PG_640K)) begin
      target = MMC_T_RAM;                          // [R4]
    end else if (!cfg.split_map_disable && pg >= sp_pg && pg < sp_pg + sp_len) begin
      target = MMC_T_SPLIT;                        // [R5] [R8] [R9]
    end else if (cfg.bank_en[0] && pg >= MMC_PG_1M && addr[31:26] == 6'h00 &&
                 (addr[25:20] >> sh0) == (win_m >> sh0)) begin
      // The window only matches from MMC_PG_1M up, so it never claims
      // the hole between 512K and 640K or the ROM areas.  [R4]
      target   = MMC_T_RAM;
      bank_hit = 4'h1;                             // [R15] [R16]
    end
  end

endmodule : mmc_decode
`default_nettype wire

/* File: hw/mmc_top.sv */
/*
  Memory map configuration register bank with its address decoder.
  Holds the two I/O encoding registers and the extended setup registers,
  and classifies each CPU memory access from the current contents.
  Assumes a host bus strobe synchronous to clk, one access per strobe.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Shadow on: reads ROM, writes RAM
// (R2) Shadow off: reads RAM, writes to channel
// (R3) Bit0 parity disable, bit1 shadow select
// (R4) Bit2 picks 640K or 512K end
// (R5) Bit3 zero maps split, one disables
// (R6) Encoding register one all RW, reset EB
// (R7) Split is 256K or 384K
// (R8) Second register low nibble gives A23..A20
// (R9) Extension register gives A31..A24, reset zero
// (R10) Compatibility codes decode per connector
// (R11) Other sizes: 00 enables, 11 disables bank
// (R12) Second register resets E2, bits 7:6 one
// (R13) Bank enable bits control banks 2,3
// (R14) Upper nibble revision, lower resets ones
// (R15) Size register two bits per bank
// (R16) Bank 0 window aligns by part size
// (R17) Window bits give base A25..A20
// (R18) Compatibility mapping of banks to connectors
// (R19) Host shadows ROM by set, copy, clear
// (R20) Host keeps split start nonzero and aligned
// (R21) Host puts larger parts in lower banks
// (R22) Host avoids overlapping bank windows
// (R23) Only the CPU reaches these registers
// (R24) Decode follows current registers every access
module mmc_top
  import mmc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1  // Arbitrary revision value.
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_is_cpu,
  input  wire logic        reg_ext,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_hit,
  input  wire logic        mem_req,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  output logic             mem_valid,
  output mmc_target_t      mem_target,
  output logic [3:0]       mem_bank,
  output logic             parity_check_enable_out,
  output logic [3:0]       bank_enable
);

  // Register state and next values.
  logic [7:0] enc1_r, enc1_nxt;    // Shadow and bank 0 encoding.
  logic [5:0] enc2_r, enc2_nxt;    // Split low and bank 1; bits 7:6 fixed.
  logic [7:0] size_r, size_nxt;    // Part size codes.
  logic [3:0] ben_r, ben_nxt;      // Banks 2 and 3 enables.
  logic [7:0] splhi_r, splhi_nxt;  // Split upper address bits.
  logic [5:0] win0_r, win0_nxt;    // Bank 0 window.
  logic [7:0] rdata_r, rdata_nxt;  // Read data.
  logic       hit_r, hit_nxt;      // Access claimed.
  logic       mv_r, mv_nxt;        // Decode valid.
  mmc_target_t tgt_r, tgt_nxt;     // Decode result.
  logic [3:0] mb_r, mb_nxt;        // Bank hit.
  logic       par_r, par_nxt;      // Parity check enable.
  logic [3:0] be_r, be_nxt;        // Bank enables.

  logic        acc;                // A CPU access to this bank.  [R23]
  logic        all256;             // All banks carry 256K parts.
  logic [3:0]  ben_c;              // Combined enables.
  mmc_target_t dtgt;               // Decoder result.
  logic [3:0]  dbank;              // Decoder bank hit.

  mmc_cfg_if cfg ();

  // Channel masters and DMA never reach the registers.
  assign acc    = reg_sel && reg_is_cpu; // [R23]
  assign all256 = (size_r == 8'h00);

  // Bank enable from the encoding codes and ben_r.  A 256K system follows the
  // connector view where bank 2 is the upper half of connector 1.
  always_comb begin
    ben_c = 4'h0;
    if (all256) begin                                          // [R10] [R18]
      ben_c[0] = (enc1_r[5:4] == 2'h0) || (enc1_r[5:4] == 2'h1);
      ben_c[2] = (enc1_r[5:4] == 2'h0);
      ben_c[1] = (enc2_r[5:4] != 2'h3) && (enc2_r[5:4] != 2'h2);
    end else begin
      ben_c[0] = (enc1_r[5:4] == 2'h0);                        // [R11]
      ben_c[1] = (enc2_r[5:4] == 2'h0);
      ben_c[2] = (ben_r[1:0] == 2'h0);                         // [R13]
    end
    ben_c[3] = (ben_r[3:2] == 2'h0);                           // [R13]
  end

  assign cfg.shadow_rom_select      = enc1_r[MMC_B_SHADOW];     // [R3]
  assign cfg.low_split_point_select = enc1_r[MMC_B_SPLIT512];   // [R4]
  assign cfg.split_map_disable      = enc1_r[MMC_B_SPLIT_DIS];  // [R5]
  assign cfg.split_start = {splhi_r, enc2_r[3:0]};              // [R8] [R9]
  assign cfg.bank_en     = ben_c;
  assign cfg.part_size   = size_r;                              // [R15]
  assign cfg.win0        = win0_r;                              // [R17]
  assign cfg.compat_lo   = {enc2_r[5:4], enc1_r[5:4]};

  mmc_decode u_dec (
    .cfg      (cfg),
    .addr     (mem_addr),
    .wr       (mem_wr),
    .target   (dtgt),
    .bank_hit (dbank)
  );

  // Register writes and read mux.
  always_comb begin
    enc1_nxt  = enc1_r;
    enc2_nxt  = enc2_r;
    size_nxt  = size_r;
    ben_nxt   = ben_r;
    splhi_nxt = splhi_r;
    win0_nxt  = win0_r;
    rdata_nxt = rdata_r;
    hit_nxt   = 1'b0;
    if (acc) begin
      hit_nxt   = 1'b1;
      rdata_nxt = 8'h00;   // Unmapped offsets read zero and are not claimed.
      if (!reg_ext && reg_addr == MMC_OFS_ENC1) begin
        if (reg_wr) enc1_nxt = reg_wdata;                       // [R6]
        rdata_nxt = enc1_r;
      end else if (!reg_ext && reg_addr == MMC_OFS_ENC2) begin
        if (reg_wr) enc2_nxt = reg_wdata[5:0];
        rdata_nxt = {MMC_ENC2_RSVD, enc2_r};                    // [R12]
      end else if (reg_ext && reg_addr == MMC_OFS_SIZE) begin
        if (reg_wr) size_nxt = reg_wdata;                       // [R15]
        rdata_nxt = size_r;
      end else if (reg_ext && reg_addr == MMC_OFS_BANKEN) begin
        if (reg_wr) ben_nxt = reg_wdata[3:0];                   // [R13]
        rdata_nxt = {REVISION, ben_r};                          // [R14]
      end else if (reg_ext && reg_addr == MMC_OFS_SPLHI) begin
        if (reg_wr) splhi_nxt = reg_wdata;                      // [R9]
        rdata_nxt = splhi_r;
      end else if (reg_ext && reg_addr == MMC_OFS_WIN0) begin
        if (reg_wr) win0_nxt = reg_wdata[5:0];                  // [R17]
        rdata_nxt = {2'h0, win0_r};
      end else begin
        hit_nxt = 1'b0;
      end
    end
  end

  // Decode result and static outputs, registered so outputs are flops.
  always_comb begin
    mv_nxt  = mem_req;
    tgt_nxt = mem_req ? dtgt : MMC_T_NONE;                      // [R24]
    mb_nxt  = mem_req ? dbank : 4'h0;
    par_nxt = ~enc1_r[MMC_B_PARITY_DIS];                        // [R3]
    be_nxt  = ben_c;
  end

  // Single state register bank.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc1_r  <= MMC_RST_ENC1;
      enc2_r  <= MMC_RST_ENC2[5:0];
      size_r  <= MMC_RST_SIZE;
      ben_r   <= MMC_RST_BANKEN;
      splhi_r <= MMC_RST_SPLHI;
      win0_r  <= MMC_RST_WIN0;
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
      mv_r    <= 1'b0;
      tgt_r   <= MMC_T_NONE;
      mb_r    <= 4'h0;
      par_r   <= 1'b0;
      be_r    <= 4'h0;
    end else begin
      enc1_r  <= enc1_nxt;
      enc2_r  <= enc2_nxt;
      size_r  <= size_nxt;
      ben_r   <= ben_nxt;
      splhi_r <= splhi_nxt;
      win0_r  <= win0_nxt;
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
      mv_r    <= mv_nxt;
      tgt_r   <= tgt_nxt;
      mb_r    <= mb_nxt;
      par_r   <= par_nxt;
      be_r    <= be_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_hit    = hit_r;
  assign mem_valid  = mv_r;
  assign mem_target = tgt_r;
  assign mem_bank   = mb_r;
  assign parity_check_enable_out = par_r;
  assign bank_enable = be_r;

  // Checks on the decode and registers.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_shadow_read_rom: assert property (          // [R1]
    mem_req && !mem_wr && enc1_r[1] && mem_addr[31:17] == 15'h0007
    |=> mem_target == MMC_T_ROM) else $error("shadow read not to ROM");
  a_shadow_off_wr: assert property (            // [R2]
    mem_req && mem_wr && !enc1_r[1] && mem_addr[31:17] == 15'h0007
    |=> mem_target == MMC_T_CHAN) else $error("shadow-off write not to channel");
  a_parity_follow: assert property (            // [R3]
    ##1 parity_check_enable_out == !$past(enc1_r[0]))
    else $error("parity enable wrong");
  a_enc1_rw: assert property (                  // [R6]
    acc && reg_wr && !reg_ext && reg_addr == MMC_OFS_ENC1
    |=> enc1_r == $past(reg_wdata)) else $error("enc1 write not stored");
  a_enc2_rsvd: assert property (                // [R12]
    $past(acc) && !$past(reg_ext) && $past(reg_addr) == MMC_OFS_ENC2
    |-> reg_rdata[7:6] == 2'h3) else $error("enc2 reserved bits");
  a_rev_nibble: assert property (               // [R14]
    $past(acc) && $past(reg_ext) && $past(reg_addr) == MMC_OFS_BANKEN
    |-> reg_rdata[7:4] == REVISION) else $error("revision nibble");
  a_split_hit: assert property (                // [R5]
    mem_req && enc1_r[3] |=> mem_target != MMC_T_SPLIT)
    else $error("split while disabled");
  a_cpu_only: assert property (                 // [R23]
    reg_sel && !reg_is_cpu |=> !reg_hit) else $error("non-CPU access claimed");
  a_bank3_dis: assert property (                // [R13]
    ben_r[3:2] == 2'h3 |=> !bank_enable[3]) else $error("bank 3 not disabled");

  c_shadow_wr: cover property (mem_req && mem_wr && enc1_r[1]);
  c_split: cover property (mem_req ##1 mem_target == MMC_T_SPLIT);
  c_ext_wr: cover property (acc && reg_wr && reg_ext);
  c_bank0: cover property (mem_valid && mem_bank[0]);

endmodule : mmc_top
`default_nettype wire

/* File: test/mmc_host_model.sv */
/*
  Host processor model: issues register strobes and memory requests.
  Assumes the bench clock and the mmc_top strobe timing.
*/
`timescale 1ns/1ps
`default_nettype none
module mmc_host_model
  import mmc_pkg::*;
(
  input  wire logic         clk,
  output var logic          reg_sel,
  output var logic          reg_wr,
  output var logic          reg_is_cpu,
  output var logic          reg_ext,
  output var logic [8:0]    reg_addr,
  output var logic [7:0]    reg_wdata,
  input  wire logic [7:0]   reg_rdata,
  input  wire logic         reg_hit,
  output var logic          mem_req,
  output var logic          mem_wr,
  output var logic [31:0]   mem_addr,
  input  wire mmc_target_t  mem_target,
  input  wire logic [3:0]   mem_bank
);
  // Bus idle at time zero.
  initial begin
    {reg_sel, reg_wr, reg_is_cpu, reg_ext, mem_req, mem_wr} = 6'h00;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    mem_addr = 32'h0;
  end

  // One access: strobe for one edge, answer taken a cycle later.
  // Parked address and data lines show inverted values so stale data never looks valid.
  task automatic acc(input logic ext, input logic cpu, input logic wr,
                     input logic [8:0] a, input logic [7:0] d,
                     output logic [7:0] rd, output logic hit);
    @(negedge clk);
    {reg_sel, reg_wr, reg_is_cpu, reg_ext} = {1'h1, wr, cpu, ext};
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    rd = reg_rdata;
    hit = reg_hit;
    reg_sel = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge clk);
  endtask : acc

  // One memory cycle classified by the decoder a cycle later.
  task automatic probe(input logic [31:0] a, input logic wr,
                       output mmc_target_t t, output logic [3:0] b);
    @(negedge clk);
    {mem_req, mem_wr} = {1'h1, wr};
    mem_addr = a;
    @(negedge clk);
    t = mem_target;
    b = mem_bank;
    mem_req = 1'h0;
    mem_addr = ~a;
  endtask : probe
endmodule : mmc_host_model
`default_nettype wire

/* File: test/tb_mmc_top.sv */
/*
  Self-checking bench for the memory map configuration block.
  Assumes the host model drives every bus input of mmc_top.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  fail_count++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module tb_mmc_top
  import mmc_pkg::*;
;
  localparam logic [3:0] REV = 4'h6;  // Arbitrary revision value.
  logic clk, arst_n, reg_sel, reg_wr, reg_is_cpu, reg_ext, hit_v;
  logic mem_req, mem_wr, mem_valid, par_en;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_v;
  logic reg_hit;
  logic [31:0] mem_addr;
  logic [3:0] mem_bank, bank_en, bk_v;
  mmc_target_t mem_target, tg_v;
  int fail_count, check_count;

  mmc_top #(.REVISION(REV)) mmc_top_i (.clk(clk), .arst_n(arst_n),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_is_cpu(reg_is_cpu),
    .reg_ext(reg_ext), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_valid(mem_valid),
    .mem_target(mem_target), .mem_bank(mem_bank),
    .parity_check_enable_out(par_en), .bank_enable(bank_en));
  mmc_host_model mmc_host_model_i (.clk(clk), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_is_cpu(reg_is_cpu), .reg_ext(reg_ext),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_target(mem_target), .mem_bank(mem_bank));

  // Clock at 40 MHz.
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run, shared by the tests and the watchdog.
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Claimed CPU write.
  task automatic wrr(input logic e, input logic [8:0] a, input logic [7:0] d);
    mmc_host_model_i.acc(e, 1'h1, 1'h1, a, d, rd_v, hit_v);
    `CHK("write hit", 1'h1, hit_v)
  endtask : wrr

  // CPU read compared with an expected byte.
  task automatic rdc(input logic e, input logic [8:0] a, input logic [7:0] x);
    mmc_host_model_i.acc(e, 1'h1, 1'h0, a, 8'h00, rd_v, hit_v);
    `CHK("read data", x, rd_v)
  endtask : rdc

  // Memory cycle expected to land on target t, or on anything but t.
  task automatic mp(input logic [31:0] a, input logic w, input mmc_target_t t,
                    input logic is);
    mmc_host_model_i.probe(a, w, tg_v, bk_v);
    `CHK("target match", is, tg_v === t)
    `CHK("mem valid", 1'h1, mem_valid)
  endtask : mp

  // The watchdog allows about thirty times the expected run.
  initial begin
    #(25 * 4000);
    fail_count++;
    close_out();
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    arst_n = 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk) arst_n = 1'h1;
    // Power-on contents and the parity output they imply.
    rdc(1'h0, MMC_OFS_ENC1, 8'hEB);
    `CHK("parity out", 1'h0, par_en)
    rdc(1'h0, MMC_OFS_ENC2, 8'hE2);
    rdc(1'h1, MMC_OFS_SIZE, 8'h00);
    rdc(1'h1, MMC_OFS_BANKEN, {REV, 4'hF});
    rdc(1'h1, MMC_OFS_SPLHI, 8'h00);
    rdc(1'h1, MMC_OFS_WIN0, 8'h00);
    $display("test reset values done");
    // A non-CPU master is ignored; an unmapped place is not claimed.
    mmc_host_model_i.acc(1'h0, 1'h0, 1'h1, MMC_OFS_ENC1, 8'h00, rd_v, hit_v);
    `CHK("foreign hit", 1'h0, hit_v)
    rdc(1'h0, MMC_OFS_ENC1, 8'hEB);
    mmc_host_model_i.acc(1'h1, 1'h1, 1'h0, 9'h1FF, 8'h00, rd_v, hit_v);
    `CHK("unmapped hit", 1'h0, hit_v)
    wrr(1'h0, MMC_OFS_ENC1, 8'h5A);
    rdc(1'h0, MMC_OFS_ENC1, 8'h5A);
    wrr(1'h0, MMC_OFS_ENC2, 8'h00);
    rdc(1'h0, MMC_OFS_ENC2, 8'hC0);
    $display("test access rights done");
    // Shadow sequence: set, copy, clear, with no extended accesses.
    wrr(1'h0, MMC_OFS_ENC1, 8'h0B);
    mp(32'h000E0000, 1'h0, MMC_T_ROM, 1'h1);
    mp(32'h000FFFFF, 1'h1, MMC_T_RAM, 1'h1);
    wrr(1'h0, MMC_OFS_ENC1, 8'h08);
    `CHK("parity out", 1'h1, par_en)
    mp(32'h000E0000, 1'h0, MMC_T_RAM, 1'h1);
    mp(32'h000FFFFF, 1'h1, MMC_T_CHAN, 1'h1);
    $display("test shadow done");
    // Split region at 0x01300000, nonzero start before enabling.
    mp(32'h0009FFFF, 1'h0, MMC_T_RAM, 1'h1);
    wrr(1'h0, MMC_OFS_ENC2, 8'h03);
    wrr(1'h1, MMC_OFS_SPLHI, 8'h01);
    wrr(1'h0, MMC_OFS_ENC1, 8'h00);
    mp(32'h01300000, 1'h0, MMC_T_SPLIT, 1'h1);
    mp(32'h0133FFFF, 1'h0, MMC_T_SPLIT, 1'h1);
    mp(32'h01340000, 1'h0, MMC_T_SPLIT, 1'h0);
    wrr(1'h0, MMC_OFS_ENC1, 8'h06);
    mp(32'h0135FFFF, 1'h0, MMC_T_SPLIT, 1'h1);
    mp(32'h01360000, 1'h0, MMC_T_SPLIT, 1'h0);
    mp(32'h0009FFFF, 1'h0, MMC_T_RAM, 1'h0);
    wrr(1'h0, MMC_OFS_ENC1, 8'h0C);
    mp(32'h01300000, 1'h0, MMC_T_SPLIT, 1'h0);
    $display("test split done");
    // Compatibility mode: code 01 enables bank 0 and not bank 2.
    wrr(1'h0, MMC_OFS_ENC1, 8'h18);
    `CHK("compat banks", 2'h1, {bank_en[2], bank_en[0]})
    // Equal 1M parts in all banks, windows kept apart.
    wrr(1'h1, MMC_OFS_SIZE, 8'hAA);
    rdc(1'h1, MMC_OFS_SIZE, 8'hAA);
    wrr(1'h0, MMC_OFS_ENC1, 8'h08);
    wrr(1'h0, MMC_OFS_ENC2, 8'h33);
    wrr(1'h1, MMC_OFS_BANKEN, 8'h0C);
    `CHK("bank enable", 4'h5, bank_en)
    rdc(1'h1, MMC_OFS_BANKEN, {REV, 4'hC});
    rdc(1'h0, MMC_OFS_ENC2, 8'hF3);
    $display("test bank enables done");
    // Bank 0 moved to the 4 MB boundary.
    wrr(1'h1, MMC_OFS_WIN0, 8'h05);
    rdc(1'h1, MMC_OFS_WIN0, 8'h05);
    mmc_host_model_i.probe(32'h00400000, 1'h0, tg_v, bk_v);
    `CHK("bank0 hit", 1'h1, bk_v[0])
    mmc_host_model_i.probe(32'h003FFFFF, 1'h0, tg_v, bk_v);
    `CHK("bank0 below", 1'h0, bk_v[0])
    mmc_host_model_i.probe(32'h00800000, 1'h0, tg_v, bk_v);
    `CHK("bank0 above", 1'h0, bk_v[0])
    $display("test window done");
    close_out();
  end
endmodule : tb_mmc_top
`default_nettype wire
